// ### split_timer_pkg.sv
// Package with register map, field positions, reset values and timing constants for the timer.
package split_timer_pkg;

   // Register addresses on the special-function register port.
   localparam logic [7:0] TIMER_CTRL_ADDR = 8'h91;
   localparam logic [7:0] TIMER_COUNT_HIGH_ADDR = 8'hCD;
   localparam logic [7:0] COUNT_LOW_ADDR = 8'h92;
   localparam logic [7:0] RELOAD_LOW_ADDR = 8'h93;
   localparam logic [7:0] RELOAD_HIGH_ADDR = 8'h94;

   // Bit positions inside the control register.
   localparam int HIGH_FLAG_BIT = 7;
   localparam int LOW_FLAG_BIT = 6;
   localparam int LOW_IRQ_EN_BIT = 5;
   localparam int SPLIT_BIT = 3;
   localparam int RUN_BIT = 2;
   localparam int EXT_TICK_BIT = 0;

   // Values after reset, and the top value of a count byte.
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [7:0] BYTE_MAX = 8'hFF;

   // Core clock rate and the two tick dividers.
   localparam int CLK_HZ = 20000000;
   localparam int CORE_DIV = 12;
   localparam int EXT_DIV = 8;
   localparam logic [3:0] CORE_DIV_LAST = 4'(CORE_DIV - 1);
   localparam logic [2:0] EXT_DIV_LAST = 3'(EXT_DIV - 1);

   // Software-visible control fields held by the block.
   typedef struct packed {
      logic high_overflow_flag;
      logic low_overflow_flag;
      logic low_overflow_irq_en;
      logic split_mode_select;
      logic run_control;
      logic ext_tick_select;
   } ctrl_s;

   // Counter and reload bytes travel together.
   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
   } pair_s;

endpackage : split_timer_pkg

// ### split_autoreload_timer.sv
// Split-capable auto-reload timer with its register port and tick generation.
`timescale 1ns/1ps
module split_autoreload_timer
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic timer_irq_en,
   input wire logic high_byte_clock_sel,
   input wire logic low_byte_clock_sel,
   input wire logic capture_mode,
   input wire logic ext_clk_pin,
   input wire logic capture_pin,
   output logic [7:0] sfr_rdata,
   output logic timer_irq
);

   // Three-stage synchronisers for the two pins.
   logic [2:0] ext_sync_ff;
   logic [2:0] cap_sync_ff;
   // Filtered pin levels, updated only when stages two and three agree.
   logic ext_level_ff;
   logic cap_level_ff;
   logic nxt_ext_level;
   logic nxt_cap_level;
   // Tick dividers.
   logic [3:0] core_div_ff;
   logic [3:0] nxt_core_div;
   logic [2:0] ext_div_ff;
   logic [2:0] nxt_ext_div;
   // Timer state.
   split_timer_pkg::ctrl_s ctrl_ff;
   split_timer_pkg::ctrl_s nxt_ctrl;
   split_timer_pkg::pair_s count_ff;
   split_timer_pkg::pair_s nxt_count;
   split_timer_pkg::pair_s reload_ff;
   split_timer_pkg::pair_s nxt_reload;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;
   logic irq_ff;
   logic nxt_irq;
   // Combinational helpers.
   logic ext_rise;
   logic cap_rise;
   logic core_tick;
   logic ext_tick;
   logic sel_tick;
   logic tick_low;
   logic tick_high;
   logic low_wrap;
   logic high_wrap;
   logic capture_now;
   logic wr_ctrl;
   logic wr_high;
   logic wr_low;
   logic [7:0] ctrl_view;

   assign sfr_rdata = rdata_ff;
   assign timer_irq = irq_ff;

   // Pin synchronisers; the first stage feeds only the second.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ext_sync_ff <= 3'h0;
         cap_sync_ff <= 3'h0;
      end
      else
      begin
         ext_sync_ff <= {ext_sync_ff[1:0], ext_clk_pin};
         cap_sync_ff <= {cap_sync_ff[1:0], capture_pin};
      end
   end

   // A pin change counts only when the two later stages agree, which rejects one-cycle glitches.
   always_comb
   begin
      nxt_ext_level = ext_level_ff;
      nxt_cap_level = cap_level_ff;
      if (ext_sync_ff[1] == ext_sync_ff[2])
      begin
         nxt_ext_level = ext_sync_ff[2];
      end
      if (cap_sync_ff[1] == cap_sync_ff[2])
      begin
         nxt_cap_level = cap_sync_ff[2];
      end
   end

   // Edges of the filtered levels.
   assign ext_rise = nxt_ext_level & ~ext_level_ff;
   assign cap_rise = nxt_cap_level & ~cap_level_ff;

   // Dividers: core clock by twelve, external rising edges by eight.
   always_comb
   begin
      nxt_core_div = (core_div_ff == split_timer_pkg::CORE_DIV_LAST) ? 4'h0 : core_div_ff + 4'h1;
      nxt_ext_div = ext_div_ff;
      if (ext_rise)
      begin
         nxt_ext_div = ext_div_ff + 3'h1;
      end
   end

   assign core_tick = (core_div_ff == split_timer_pkg::CORE_DIV_LAST);
   assign ext_tick = ext_rise && (ext_div_ff == split_timer_pkg::EXT_DIV_LAST);
   assign sel_tick = ctrl_ff.ext_tick_select ? ext_tick : core_tick;
   // A clock select of one bypasses the divided tick and counts every core clock.
   assign tick_low = low_byte_clock_sel ? 1'b1 : sel_tick;
   assign tick_high = high_byte_clock_sel ? 1'b1 : sel_tick;

   // Register port decode.
   assign wr_ctrl = sfr_wr && (sfr_addr == split_timer_pkg::TIMER_CTRL_ADDR);
   assign wr_high = sfr_wr && (sfr_addr == split_timer_pkg::TIMER_COUNT_HIGH_ADDR);
   assign wr_low = sfr_wr && (sfr_addr == split_timer_pkg::COUNT_LOW_ADDR);

   // Unused bits 4 and 1 are not stored and always read as zero.
   assign ctrl_view = {ctrl_ff.high_overflow_flag, ctrl_ff.low_overflow_flag,
                       ctrl_ff.low_overflow_irq_en, 1'b0, ctrl_ff.split_mode_select,
                       ctrl_ff.run_control, 1'b0, ctrl_ff.ext_tick_select};

   // Wrap conditions; in 16-bit mode the high byte steps only on a low byte wrap.
   always_comb
   begin
      if (ctrl_ff.split_mode_select)
      begin
         // The low byte ignores run control in split mode.
         low_wrap = tick_low && (count_ff.low == split_timer_pkg::BYTE_MAX);
         high_wrap = ctrl_ff.run_control && tick_high &&
                     (count_ff.high == split_timer_pkg::BYTE_MAX);
      end
      else
      begin
         low_wrap = ctrl_ff.run_control && tick_low &&
                    (count_ff.low == split_timer_pkg::BYTE_MAX);
         high_wrap = low_wrap && (count_ff.high == split_timer_pkg::BYTE_MAX);
      end
   end

   assign capture_now = capture_mode && ctrl_ff.split_mode_select && cap_rise;

   // Next state of counters, reloads and control.
   always_comb
   begin
      nxt_count = count_ff;
      nxt_reload = reload_ff;
      nxt_ctrl = ctrl_ff;
      // Counting.
      if (ctrl_ff.split_mode_select)
      begin
         if (low_wrap)
         begin
            nxt_count.low = reload_ff.low;
         end
         else if (tick_low)
         begin
            nxt_count.low = count_ff.low + 8'h01;
         end
         if (high_wrap)
         begin
            nxt_count.high = reload_ff.high;
         end
         else if (ctrl_ff.run_control && tick_high)
         begin
            nxt_count.high = count_ff.high + 8'h01;
         end
      end
      else if (ctrl_ff.run_control && tick_low)
      begin
         // Sixteen-bit count reloads both bytes only on the full wrap.
         if (high_wrap)
         begin
            nxt_count = reload_ff;
         end
         else
         begin
            nxt_count = 16'(count_ff + 16'h0001);
         end
      end
      // Software writes to a count byte take priority over counting in that cycle.
      if (wr_high)
      begin
         nxt_count.high = sfr_wdata;
      end
      if (wr_low)
      begin
         nxt_count.low = sfr_wdata;
      end
      // Reload registers: software writes, then capture, which wins if both land together.
      if (sfr_wr && (sfr_addr == split_timer_pkg::RELOAD_LOW_ADDR))
      begin
         nxt_reload.low = sfr_wdata;
      end
      if (sfr_wr && (sfr_addr == split_timer_pkg::RELOAD_HIGH_ADDR))
      begin
         nxt_reload.high = sfr_wdata;
      end
      if (capture_now)
      begin
         nxt_reload = count_ff;
      end
      // Control writes; flags only clear through software.
      if (wr_ctrl)
      begin
         nxt_ctrl.high_overflow_flag = sfr_wdata[split_timer_pkg::HIGH_FLAG_BIT];
         nxt_ctrl.low_overflow_flag = sfr_wdata[split_timer_pkg::LOW_FLAG_BIT];
         nxt_ctrl.low_overflow_irq_en = sfr_wdata[split_timer_pkg::LOW_IRQ_EN_BIT];
         nxt_ctrl.split_mode_select = sfr_wdata[split_timer_pkg::SPLIT_BIT];
         nxt_ctrl.run_control = sfr_wdata[split_timer_pkg::RUN_BIT];
         nxt_ctrl.ext_tick_select = sfr_wdata[split_timer_pkg::EXT_TICK_BIT];
      end
      // Hardware sets override a clearing write in the same cycle so no event is lost.
      if (high_wrap || capture_now)
      begin
         nxt_ctrl.high_overflow_flag = 1'b1;
      end
      if (low_wrap)
      begin
         nxt_ctrl.low_overflow_flag = 1'b1;
      end
   end

   // Read data and interrupt request, both registered.
   always_comb
   begin
      nxt_rdata = rdata_ff;
      if (sfr_rd)
      begin
         case (sfr_addr)
            split_timer_pkg::TIMER_CTRL_ADDR: nxt_rdata = ctrl_view;
            split_timer_pkg::TIMER_COUNT_HIGH_ADDR: nxt_rdata = count_ff.high;
            split_timer_pkg::COUNT_LOW_ADDR: nxt_rdata = count_ff.low;
            split_timer_pkg::RELOAD_LOW_ADDR: nxt_rdata = reload_ff.low;
            split_timer_pkg::RELOAD_HIGH_ADDR: nxt_rdata = reload_ff.high;
            default: nxt_rdata = 8'h00;
         endcase
      end
      nxt_irq = timer_irq_en && (nxt_ctrl.high_overflow_flag ||
                (nxt_ctrl.low_overflow_flag && nxt_ctrl.low_overflow_irq_en));
   end

   // State registers.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ext_level_ff <= 1'b0;
         cap_level_ff <= 1'b0;
         core_div_ff <= 4'h0;
         ext_div_ff <= 3'h0;
         ctrl_ff <= split_timer_pkg::ctrl_s'(6'h00);
         count_ff <= {split_timer_pkg::BYTE_RESET, split_timer_pkg::BYTE_RESET};
         reload_ff <= {split_timer_pkg::BYTE_RESET, split_timer_pkg::BYTE_RESET};
         rdata_ff <= 8'h00;
         irq_ff <= 1'b0;
      end
      else
      begin
         ext_level_ff <= nxt_ext_level;
         cap_level_ff <= nxt_cap_level;
         core_div_ff <= nxt_core_div;
         ext_div_ff <= nxt_ext_div;
         ctrl_ff <= nxt_ctrl;
         count_ff <= nxt_count;
         reload_ff <= nxt_reload;
         rdata_ff <= nxt_rdata;
         irq_ff <= nxt_irq;
      end
   end

   // Split low byte at its top value wraps to its reload and raises the low flag.
   AST_SPLIT_LOW_WRAP: assert property (@(posedge clk) disable iff (!rst_b)
      (ctrl_ff.split_mode_select && tick_low && count_ff.low == 8'hFF && !wr_low)
      |=> (count_ff.low == $past(reload_ff.low)) && ctrl_ff.low_overflow_flag)
      else $error("split low byte did not wrap to reload");

   // A high wrap sets the high flag on the next edge.
   AST_HIGH_FLAG_SET: assert property (@(posedge clk) disable iff (!rst_b)
      high_wrap |=> ctrl_ff.high_overflow_flag)
      else $error("high flag missing after wrap");

   // Without a control write the high flag stays set.
   AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (!rst_b)
      (ctrl_ff.high_overflow_flag && !wr_ctrl) |=> ctrl_ff.high_overflow_flag)
      else $error("high flag cleared without software");

   // A pending high flag with the timer enabled keeps the request up; the enable is registered
   // together with the flags, so its value one edge back is the one that counts.
   AST_HIGH_IRQ: assert property (@(posedge clk) disable iff (!rst_b)
      ($past(timer_irq_en) && ctrl_ff.high_overflow_flag) |-> timer_irq)
      else $error("high flag did not request interrupt");

   // Low flag requests only together with its own enable.
   AST_LOW_IRQ: assert property (@(posedge clk) disable iff (!rst_b)
      (!ctrl_ff.high_overflow_flag && ctrl_ff.low_overflow_flag && !ctrl_ff.low_overflow_irq_en)
      |-> !timer_irq)
      else $error("low flag requested without its enable");

   // Run off in split mode freezes the high byte.
   AST_RUN_GATE: assert property (@(posedge clk) disable iff (!rst_b)
      (ctrl_ff.split_mode_select && !ctrl_ff.run_control && !wr_high) |=> $stable(count_ff.high))
      else $error("high byte counted while stopped");

   // Reading control shows zero in the unused bits.
   AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
      (sfr_rd && sfr_addr == 8'h91) |=> (sfr_rdata[4] == 1'b0 && sfr_rdata[1] == 1'b0))
      else $error("unused control bits read nonzero");

   // A split capture copies the counts into the reload bytes.
   AST_CAPTURE_COPY: assert property (@(posedge clk) disable iff (!rst_b)
      capture_now |=> (reload_ff == $past(count_ff)) && ctrl_ff.high_overflow_flag)
      else $error("capture did not latch counts");

   // The divide-by-twelve tick is followed by eight quiet cycles at least.
   AST_CORE_DIV: assert property (@(posedge clk) disable iff (!rst_b)
      core_tick |=> !core_tick [*8])
      else $error("core tick spacing wrong");

   // Reading the high count register returns the high byte.
   AST_READ_HIGH: assert property (@(posedge clk) disable iff (!rst_b)
      (sfr_rd && sfr_addr == 8'hCD) |=> sfr_rdata == $past(count_ff.high))
      else $error("high count read mismatch");

   COV_SPLIT_HIGH_WRAP: cover property (@(posedge clk) disable iff (!rst_b)
      ctrl_ff.split_mode_select && high_wrap);
   COV_FULL_WRAP: cover property (@(posedge clk) disable iff (!rst_b)
      !ctrl_ff.split_mode_select && high_wrap);
   COV_CAPTURE: cover property (@(posedge clk) disable iff (!rst_b) capture_now);

endmodule : split_autoreload_timer

// ### tb.sv
// Self-checking testbench for the split auto-reload timer.
`timescale 1ns/1ps
module tb;
   // Bench-driven inputs, all given a value at time zero.
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] sfr_addr = 8'h00;
   logic [7:0] sfr_wdata = 8'h00;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic timer_irq_en = 1'b1;
   logic high_byte_clock_sel = 1'b0;
   logic low_byte_clock_sel = 1'b0;
   logic capture_mode = 1'b0;
   logic ext_clk_pin = 1'b0;
   logic capture_pin = 1'b0;
   // Outputs of the timer.
   logic [7:0] sfr_rdata;
   logic timer_irq;
   // Counters of mismatches and comparisons.
   int fails = 0;
   int n_checks = 0;
   // Scratch read values.
   logic [7:0] v;
   logic [7:0] w;
   // One table row: a register write and the read-back and interrupt it should give.
   typedef struct {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic [7:0] rdata;
      logic [7:0] irq;
   } row_s;
   row_s rows [11];

   split_autoreload_timer u_split_autoreload_timer (
      .clk(clk),
      .rst_b(rst_b),
      .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata),
      .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd),
      .timer_irq_en(timer_irq_en),
      .high_byte_clock_sel(high_byte_clock_sel),
      .low_byte_clock_sel(low_byte_clock_sel),
      .capture_mode(capture_mode),
      .ext_clk_pin(ext_clk_pin),
      .capture_pin(capture_pin),
      .sfr_rdata(sfr_rdata),
      .timer_irq(timer_irq)
   );

   // The 20 MHz core clock, 50 ns period.
   always #25 clk = ~clk;

   // Compares a seen value with an expected one and reports a difference.
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // One-cycle write strobe; the strobe drops one edge before any next request.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clk);
      sfr_wr <= 1'b0;
   endtask : wr

   // Read data is registered, so it is taken one edge after the strobe is seen.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge clk);
      sfr_rd <= 1'b0;
      @(posedge clk);
      #1 d = sfr_rdata;
   endtask : rd

   // A pin pulse held one cycle past the synchroniser's minimum of two cycles.
   // The flag picks the capture pin, otherwise the external clock pin is pulsed.
   task automatic pulse(input logic on_capture, input int n);
      repeat (n)
      begin
         @(posedge clk);
         if (on_capture)
            capture_pin <= 1'b1;
         else
            ext_clk_pin <= 1'b1;
         repeat (3) @(posedge clk);
         capture_pin <= 1'b0;
         ext_clk_pin <= 1'b0;
         repeat (3) @(posedge clk);
      end
   endtask : pulse

   // Prints the counts and the verdict, then stops the run.
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : test_done

   // Watchdog well beyond the few hundred cycles the sequence needs.
   initial
   begin
      repeat (30000) @(posedge clk);
      fails++;
      test_done();
   end

   // Main sequence: reset, table of register accesses, then counting cases.
   initial
   begin
      rows = '{'{8'h91, 8'h12, 8'h00, 8'h00}, '{8'h91, 8'hC0, 8'hC0, 8'h01},
               '{8'h91, 8'h60, 8'h60, 8'h01}, '{8'h91, 8'h40, 8'h40, 8'h00},
               '{8'h91, 8'h29, 8'h29, 8'h00}, '{8'h91, 8'h00, 8'h00, 8'h00},
               '{8'hCD, 8'h3C, 8'h3C, 8'h00}, '{8'h92, 8'h77, 8'h77, 8'h00},
               '{8'h93, 8'hA5, 8'hA5, 8'h00}, '{8'h94, 8'h5A, 8'h5A, 8'h00},
               '{8'h55, 8'hFF, 8'h00, 8'h00}};
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      rd(split_timer_pkg::TIMER_CTRL_ADDR, v);
      chk("ctrl reset", v, split_timer_pkg::CTRL_RESET);
      rd(split_timer_pkg::TIMER_COUNT_HIGH_ADDR, v);
      chk("count high reset", v, 8'h00);
      foreach (rows[i])
      begin
         wr(rows[i].addr, rows[i].wdata);
         rd(rows[i].addr, v);
         chk("table read", v, rows[i].rdata);
         chk("table irq", {7'h00, timer_irq}, rows[i].irq);
      end
      // Split mode, run off: low byte runs every core clock, high byte holds.
      @(posedge clk);
      low_byte_clock_sel <= 1'b1;
      high_byte_clock_sel <= 1'b1;
      wr(8'h93, 8'h00);
      wr(8'h91, 8'h08);
      rd(8'h92, v);
      repeat (5) @(posedge clk);
      rd(8'h92, w);
      chk("low free run", w - v, 8'h08);
      rd(8'hCD, v);
      chk("high held", v, 8'h3C);
      // High byte wraps from its top and reloads, leaving the low flag clear.
      wr(8'h94, 8'h10);
      wr(8'hCD, 8'hF8);
      wr(8'h91, 8'h0C);
      repeat (12) @(posedge clk);
      rd(8'h91, v);
      chk("split high flag", v, 8'h8C);
      chk("split irq", {7'h00, timer_irq}, 8'h01);
      wr(8'h91, 8'h88);
      rd(8'hCD, v);
      chk("high reloaded", {7'h00, v >= 8'h10 && v < 8'h20}, 8'h01);
      wr(8'h91, 8'h08);
      rd(8'h91, v);
      chk("software clear", v, 8'h08);
      chk("irq cleared", {7'h00, timer_irq}, 8'h00);
      // External tick: one count for every eighth rising edge of the pin.
      @(posedge clk);
      low_byte_clock_sel <= 1'b0;
      high_byte_clock_sel <= 1'b0;
      wr(8'h91, 8'h09);
      wr(8'h92, 8'h00);
      pulse(1'b0, 16);
      repeat (6) @(posedge clk);
      rd(8'h92, v);
      chk("ext tick count", v, 8'h02);
      // Core tick: one count per twelve core clocks; the free divider phase gives +-1.
      wr(8'h91, 8'h08);
      wr(8'h92, 8'h00);
      repeat (120) @(posedge clk);
      rd(8'h92, v);
      chk("core tick count", {7'h00, v >= 8'h09 && v <= 8'h0B}, 8'h01);
      // 16-bit wrap from all ones sets both flags and reloads the full count.
      @(posedge clk);
      low_byte_clock_sel <= 1'b1;
      wr(8'h91, 8'h00);
      wr(8'h94, 8'hAB);
      wr(8'h93, 8'hCD);
      wr(8'hCD, 8'hFF);
      wr(8'h92, 8'hF0);
      wr(8'h91, 8'h04);
      repeat (30) @(posedge clk);
      rd(8'h91, v);
      chk("wide flags", v, 8'hC4);
      wr(8'h91, 8'hC0);
      rd(8'hCD, v);
      chk("wide reload", v, 8'hAB);
      chk("wide irq", {7'h00, timer_irq}, 8'h01);
      // Capture in split mode copies the count and raises the high flag.
      @(posedge clk);
      low_byte_clock_sel <= 1'b0;
      capture_mode <= 1'b1;
      wr(8'h91, 8'h08);
      wr(8'hCD, 8'h5A);
      pulse(1'b1, 1);
      rd(8'h94, v);
      chk("capture reload", v, 8'h5A);
      rd(8'h91, v);
      chk("capture flag", v, 8'h88);
      chk("capture irq", {7'h00, timer_irq}, 8'h01);
      // Dropping the global enable masks the pending request.
      @(posedge clk);
      timer_irq_en <= 1'b0;
      repeat (2) @(posedge clk);
      chk("irq masked", {7'h00, timer_irq}, 8'h00);
      timer_irq_en <= 1'b1;
      // Capture is ignored while the capture variant is off.
      @(posedge clk);
      capture_mode <= 1'b0;
      wr(8'h91, 8'h08);
      wr(8'hCD, 8'h33);
      pulse(1'b1, 1);
      rd(8'h94, v);
      chk("capture off reload", v, 8'h5A);
      rd(8'h91, v);
      chk("capture off flag", v, 8'h08);
      // A reset in mid-run clears flags, control and the interrupt.
      wr(8'h91, 8'hCC);
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      chk("irq in reset", {7'h00, timer_irq}, 8'h00);
      rst_b <= 1'b1;
      rd(8'h91, v);
      chk("ctrl after reset", v, 8'h00);
      test_done();
   end
endmodule : tb
